// ==== pthi_core.sv ====
`timescale 1ns/1ps
module pthi_core
    import pthi_pkg::*;
(
    input  wire logic        i_clk,       // System clock, 125 MHz
    input  wire logic        i_sys_rst,   // Synchronous reset, active high
    input  wire logic        i_wr,        // Register write strobe
    input  wire logic        i_rd,        // Register read strobe
    input  wire logic [7:0]  i_addr,      // Register address
    input  wire logic [7:0]  i_wdata,     // Write data
    input  wire logic        i_meas_vld,  // New proximity result pulse
    input  wire logic [15:0] i_meas,      // Proximity result word
    output logic      [7:0]  o_rdata,     // Read data, registered
    output logic             o_int_n,     // Interrupt pad, active low
    output logic      [2:0]  o_delay,     // Modulation delay time
    output logic      [1:0]  o_freq,      // Proximity frequency
    output logic      [2:0]  o_dead       // Modulation dead time
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]  ctrl_r,   ctrl_nxt;      // Interrupt control
    logic [15:0] low_r,    low_nxt;       // Low threshold word
    logic [15:0] high_r,   high_nxt;      // High threshold word
    logic [7:0]  flags_r,  flags_nxt;     // Sticky status flags
    logic [7:0]  mod_r,    mod_nxt;       // Modulator timing
    logic [7:0]  rdata_r,  rdata_nxt;     // Read data
    logic        int_n_r,  int_n_nxt;     // Pad level
    logic        below_hit;               // Debounced low crossing
    logic        above_hit;               // Debounced high crossing
    logic        use_prox;                // Compare proximity results

    pthi_if low_bus ();
    pthi_if high_bus ();

    ////////////////////////////////////////////////////////////////////
    // Threshold comparators feeding the run counters
    assign use_prox         = ~ctrl_r[PTHI_CTL_TH_SEL];
    assign low_bus.sample   = i_meas_vld & use_prox;
    assign low_bus.beyond   = i_meas < low_r;
    assign low_bus.cnt_sel  = ctrl_r[PTHI_CTL_CNT_LSB +: 3];
    assign high_bus.sample  = i_meas_vld & use_prox;
    assign high_bus.beyond  = i_meas > high_r;
    assign high_bus.cnt_sel = ctrl_r[PTHI_CTL_CNT_LSB +: 3];
    assign below_hit        = low_bus.hit & ctrl_r[PTHI_CTL_TH_EN];
    assign above_hit        = high_bus.hit & ctrl_r[PTHI_CTL_TH_EN];

    pthi_run_counter u_low (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (low_bus)
    );

    pthi_run_counter u_high (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (high_bus)
    );

    ////////////////////////////////////////////////////////////////////
    // Register writes and flag updates
    always_comb begin
        ctrl_nxt  = ctrl_r;
        low_nxt   = low_r;
        high_nxt  = high_r;
        mod_nxt   = mod_r;
        flags_nxt = flags_r;
        if (i_wr) begin
            case (i_addr)
                PTHI_ADDR_CTRL:    ctrl_nxt       = i_wdata & 8'hfb;
                PTHI_ADDR_LOW_UP:  low_nxt[15:8]  = i_wdata;
                PTHI_ADDR_LOW_LO:  low_nxt[7:0]   = i_wdata;
                PTHI_ADDR_HIGH_UP: high_nxt[15:8] = i_wdata;
                PTHI_ADDR_HIGH_LO: high_nxt[7:0]  = i_wdata;
                PTHI_ADDR_FLAGS:   flags_nxt      = flags_r & ~i_wdata;
                PTHI_ADDR_MOD:     mod_nxt        = i_wdata;
                default:           ;                           // Unmapped: ignored
            endcase
        end
        // Events set after the clear so a set wins
        if (i_meas_vld && ctrl_r[PTHI_CTL_RDY_EN]) begin
            flags_nxt[PTHI_FLAG_READY] = 1'b1;
        end
        if (below_hit) begin
            flags_nxt[PTHI_FLAG_BELOW] = 1'b1;
        end
        if (above_hit) begin
            flags_nxt[PTHI_FLAG_ABOVE] = 1'b1;
        end
        flags_nxt = flags_nxt & PTHI_FLAGS_MSK;
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux and pad level
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_rd) begin
            case (i_addr)
                PTHI_ADDR_CTRL:    rdata_nxt = ctrl_r;
                PTHI_ADDR_LOW_UP:  rdata_nxt = low_r[15:8];
                PTHI_ADDR_LOW_LO:  rdata_nxt = low_r[7:0];
                PTHI_ADDR_HIGH_UP: rdata_nxt = high_r[15:8];
                PTHI_ADDR_HIGH_LO: rdata_nxt = high_r[7:0];
                PTHI_ADDR_FLAGS:   rdata_nxt = flags_r;
                PTHI_ADDR_MOD:     rdata_nxt = mod_r;
                default:           rdata_nxt = 8'h00;          // Unmapped reads zero
            endcase
        end
        int_n_nxt = ~(|flags_nxt);
    end

    ////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_r  <= PTHI_CTRL_RST;
            low_r   <= {PTHI_THR_RST, PTHI_THR_RST};
            high_r  <= {PTHI_THR_RST, PTHI_THR_RST};
            flags_r <= 8'h00;
            mod_r   <= PTHI_MOD_RST;
            rdata_r <= 8'h00;
            int_n_r <= 1'b1;
        end else begin
            ctrl_r  <= ctrl_nxt;
            low_r   <= low_nxt;
            high_r  <= high_nxt;
            flags_r <= flags_nxt;
            mod_r   <= mod_nxt;
            rdata_r <= rdata_nxt;
            int_n_r <= int_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata = rdata_r;
    assign o_int_n = int_n_r;
    assign o_delay = mod_r[7:5];
    assign o_freq  = mod_r[4:3];
    assign o_dead  = mod_r[2:0];
endmodule

// ==== pthi_pkg.sv ====
package pthi_pkg;
    // Register offsets (byte register addresses)
    localparam logic [7:0] PTHI_ADDR_CTRL     = 8'h89;
    localparam logic [7:0] PTHI_ADDR_LOW_UP   = 8'h8a;
    localparam logic [7:0] PTHI_ADDR_LOW_LO   = 8'h8b;
    localparam logic [7:0] PTHI_ADDR_HIGH_UP  = 8'h8c;
    localparam logic [7:0] PTHI_ADDR_HIGH_LO  = 8'h8d;
    localparam logic [7:0] PTHI_ADDR_FLAGS    = 8'h8e;
    localparam logic [7:0] PTHI_ADDR_MOD      = 8'h8f;
    // Status flag positions
    localparam int PTHI_FLAG_READY = 3;
    localparam int PTHI_FLAG_BELOW = 1;
    localparam int PTHI_FLAG_ABOVE = 0;
    // Interrupt control field positions
    localparam int PTHI_CTL_CNT_LSB  = 5;
    localparam int PTHI_CTL_RDY_EN   = 3;
    localparam int PTHI_CTL_TH_EN    = 1;
    localparam int PTHI_CTL_TH_SEL   = 0;
    // Reset values and flag mask
    localparam logic [7:0] PTHI_CTRL_RST  = 8'h00;
    localparam logic [7:0] PTHI_THR_RST   = 8'h00;
    localparam logic [7:0] PTHI_MOD_RST   = 8'h01;
    localparam logic [7:0] PTHI_FLAGS_MSK = 8'h0b;
    // Count width for up to 128 consecutive hits
    localparam int PTHI_CNT_W = 8;
endpackage

// ==== pthi_if.sv ====
`timescale 1ns/1ps
// Carries a debounced comparison request between top and counter
interface pthi_if;
    logic       sample;     // New measurement this cycle
    logic       beyond;     // Measurement is past the threshold
    logic [2:0] cnt_sel;    // Consecutive count code
    logic       hit;        // Enough consecutive samples seen
    modport ctl (output sample, output beyond, output cnt_sel, input hit);
    modport cnt (input sample, input beyond, input cnt_sel, output hit);
endinterface

// ==== pthi_run_counter.sv ====
`timescale 1ns/1ps
// Counts consecutive measurements beyond one threshold
module pthi_run_counter
    import pthi_pkg::*;
(
    input  wire logic i_clk,     // System clock
    input  wire logic i_sys_rst, // Synchronous reset, active high
    pthi_if.cnt       bus        // Comparison request
);
    logic [PTHI_CNT_W-1:0] run_r;   // Consecutive hit count
    logic [PTHI_CNT_W-1:0] run_nxt;
    logic [PTHI_CNT_W-1:0] need;    // Hits needed, 2 to the code
    logic                  hit_r;
    logic                  hit_nxt;

    assign need   = PTHI_CNT_W'(1) << bus.cnt_sel;
    assign bus.hit = hit_r;

    ////////////////////////////////////////////////////////////////////
    // Next count: restart on a miss, fire once the run reaches need
    always_comb begin
        run_nxt = run_r;
        hit_nxt = 1'b0;
        if (bus.sample) begin
            if (!bus.beyond) begin
                run_nxt = '0;
            end else if (run_r + 1'b1 >= need) begin
                run_nxt = '0;        // Restart run after firing
                hit_nxt = 1'b1;
            end else begin
                run_nxt = run_r + 1'b1;
            end
        end
    end

    // Register the count
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_r <= '0;
            hit_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            hit_r <= hit_nxt;
        end
    end
endmodule

// ==== pthi_checker.sv ====
`timescale 1ns/1ps
// Port checks on threshold interrupt block
module pthi_checker
    import pthi_pkg::*;
(
    input wire logic        i_clk,      // Clock
    input wire logic        i_sys_rst,  // Reset
    input wire logic        i_wr,       // Write
    input wire logic        i_rd,       // Read
    input wire logic [7:0]  i_addr,     // Address
    input wire logic [7:0]  i_wdata,    // Write data
    input wire logic        i_meas_vld, // Result pulse
    input wire logic [15:0] i_meas,     // Result
    input wire logic [7:0]  o_rdata,    // Read data
    input wire logic        o_int_n,    // Pad
    input wire logic [2:0]  o_delay,    // Delay
    input wire logic [1:0]  o_freq,     // Frequency
    input wire logic [2:0]  o_dead      // Dead time
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Full flag clear with no result in flight
    sequence s_clear_all;
        i_wr && i_addr == PTHI_ADDR_FLAGS && (i_wdata & PTHI_FLAGS_MSK) == PTHI_FLAGS_MSK
            && !i_meas_vld && !$past(i_meas_vld) && !$past(i_meas_vld, 2);
    endsequence
    a_pad_released: assert property (s_clear_all |=> o_int_n)
        else $error("pad low after full clear");
    a_pad_sticky: assert property (!o_int_n && !(i_wr && i_addr == PTHI_ADDR_FLAGS) |=> !o_int_n)
        else $error("pad released without clear");
    a_reset_values: assert property ($fell(i_sys_rst) |-> o_int_n && {o_delay, o_freq, o_dead} == 8'h01)
        else $error("bad reset outputs");
    a_timing_write: assert property (i_wr && i_addr == PTHI_ADDR_MOD |=> {o_delay, o_freq, o_dead} == $past(i_wdata))
        else $error("timing fields not written");
    a_timing_hold: assert property (!(i_wr && i_addr == PTHI_ADDR_MOD) |=> $stable({o_delay, o_freq, o_dead}))
        else $error("timing fields changed");
    a_unmapped_zero: assert property (i_rd && (i_addr < PTHI_ADDR_CTRL || i_addr > PTHI_ADDR_MOD) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flags_spare: assert property (i_rd && i_addr == PTHI_ADDR_FLAGS |=> o_rdata[7:4] == 4'h0 && !o_rdata[2])
        else $error("spare flag bits set");
    a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
endmodule
bind pthi_core pthi_checker i_chk (.*);

// ==== pthi_host.sv ====
`timescale 1ns/1ps
// Register host model, drives on falling edge
module pthi_host (
    input  wire logic       i_clk,   // Clock
    input  wire logic [7:0] i_rdata, // Read data
    output logic            o_wr,    // Write strobe
    output logic            o_rd,    // Read strobe
    output logic      [7:0] o_addr,  // Address
    output logic      [7:0] o_wdata  // Write data
);
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    // One-cycle write; bus shows inverse once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk);
        {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
    endtask
    // One-cycle read; data valid a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b0, ~a};
        d = i_rdata;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import pthi_pkg::*;
    logic clk = 0, rst = 1, wr, rd, vld = 0, int_n;
    logic [7:0] addr, wd, rdat, d;
    logic [15:0] meas = '0;
    logic [2:0] dly, dead;
    logic [1:0] frq;
    int bad_count = 0, check_count = 0, cyc = 0;
    always #4 clk = ~clk;
    pthi_core i_dut (.i_clk(clk), .i_sys_rst(rst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
        .i_wdata(wd), .i_meas_vld(vld), .i_meas(meas), .o_rdata(rdat), .o_int_n(int_n),
        .o_delay(dly), .o_freq(frq), .o_dead(dead));
    pthi_host i_host (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wd));
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %0t exp %h got %h", $time, e, g);
            bad_count++;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk(e, d);
    endtask
    // Send n results of one value
    task automatic ms(input logic [15:0] v, input int n);
        repeat (n) begin
            @(negedge clk);
            {vld, meas} = {1'b1, v};
            @(negedge clk);
            {vld, meas} = {1'b0, ~v};
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 9; i++) rc(8'h88 + 8'(i), (i == 7) ? 8'h01 : 8'h00);
        for (int i = 0; i < 4; i++) i_host.wr(8'h8a + 8'(i), 8'h5a + 8'(i));
        for (int i = 0; i < 4; i++) rc(8'h8a + 8'(i), 8'h5a + 8'(i));
        i_host.wr(PTHI_ADDR_MOD, 8'hb6);
        chk(8'hb6, {dly, frq, dead});
        for (int i = 0; i < 4; i++) i_host.wr(8'h8a + 8'(i), (i % 2) ? 8'h10 >> (4 * (i / 2)) : 8'h00 | 8'(i / 2));
        i_host.wr(PTHI_ADDR_CTRL, 8'h0a);
        ms(16'h0005, 1);
        rc(PTHI_ADDR_FLAGS, 8'h0a);
        chk(0, int_n);
        i_host.wr(PTHI_ADDR_FLAGS, 8'h02);
        rc(PTHI_ADDR_FLAGS, 8'h08);
        i_host.wr(PTHI_ADDR_FLAGS, 8'h08);
        chk(1, int_n);
        ms(16'h0010, 1);
        ms(16'h0100, 1);
        ms(16'h0200, 1);
        rc(PTHI_ADDR_FLAGS, 8'h09);
        i_host.wr(PTHI_ADDR_CTRL, 8'h42);
        i_host.wr(PTHI_ADDR_FLAGS, 8'hff);
        ms(16'h0005, 3);
        ms(16'h0050, 1);
        ms(16'h0005, 3);
        rc(PTHI_ADDR_FLAGS, 8'h00);
        ms(16'h0005, 1);
        rc(PTHI_ADDR_FLAGS, 8'h02);
        i_host.wr(PTHI_ADDR_CTRL, 8'he2);
        i_host.wr(PTHI_ADDR_FLAGS, 8'h0b);
        ms(16'h0005, 127);
        rc(PTHI_ADDR_FLAGS, 8'h00);
        ms(16'h0005, 1);
        rc(PTHI_ADDR_FLAGS, 8'h02);
        i_host.wr(PTHI_ADDR_CTRL, 8'h00);
        i_host.wr(PTHI_ADDR_FLAGS, 8'h0b);
        ms(16'h0005, 1);
        chk(1, int_n);
        i_host.wr(PTHI_ADDR_CTRL, 8'h0b);
        ms(16'h0005, 1);
        rc(PTHI_ADDR_FLAGS, 8'h08);
        @(negedge clk) rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        // Let two edges pass so the checker sees the reset release
        repeat (2) @(negedge clk);
        chk(9'h101, {int_n, dly, frq, dead});
        end_sim();
    end
endmodule
